/* pkg/fst_pkg.sv */
// package: register map, key values and field positions of the fetch safety timer
package fst_pkg;
    // printed offsets are not all multiples of four: kept as indices, byte address is four times
    localparam logic [7:0] IDX_TIMER_CONTROL   = 8'h5C;
    localparam logic [7:0] IDX_FIRST_KEY       = 8'h60;
    localparam logic [7:0] IDX_SECOND_KEY      = 8'h64;
    localparam logic [7:0] IDX_TIMER_STATUS    = 8'h68;
    localparam logic [7:0] IDX_COUNT_LOW       = 8'h6C;
    localparam logic [7:0] IDX_COUNT_HIGH      = 8'h6E;
    localparam logic [7:0] IDX_COUNT_HOLD      = 8'h70;
    localparam logic [7:0] IDX_MATCH_CFG_LOW   = 8'h74;
    localparam logic [7:0] IDX_MATCH_CFG_HIGH  = 8'h76;
    localparam logic [7:0] IDX_WINDOW_CFG_LOW  = 8'h78;
    localparam logic [7:0] IDX_WINDOW_CFG_HIGH = 8'h7A;
    localparam logic [7:0] IDX_IRQ_STATUS      = 8'h80;
    localparam logic [7:0] IDX_IRQ_MASK        = 8'h81;
    // field positions
    localparam int ENABLE_BIT      = 15;
    localparam int FIRST_KEY_LSB   = 8;
    localparam int SECOND_KEY_LSB  = 0;
    localparam int STAT_FIRST_KEY_ERROR_BIT   = 7;
    localparam int STAT_SECOND_KEY_ERROR_BIT   = 6;
    localparam int STAT_EVENT_BIT  = 5;
    localparam int STAT_WINDOW_BIT = 0;
    // key values
    localparam logic [7:0] FIRST_KEY_VALUE  = 8'h40;
    localparam logic [7:0] SECOND_KEY_VALUE = 8'h04;
    // interrupt status bits
    localparam int IRQ_EXPIRE_BIT = 0;
    localparam int IRQ_FIRST_KEY_ERROR_BIT   = 1;
    localparam int IRQ_SECOND_KEY_ERROR_BIT   = 2;
    localparam int IRQ_BITS       = 3;
    // reset values
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ    = 2'b11;
    localparam logic       HRESP_OKAY    = 1'b0;
endpackage

/* src/fst_timer.sv */
// fetch safety timer: fetch counter, keyed restart and ahb-lite register slave
// one clock, one asynchronous reset
// zero-wait ahb-lite register slave
// okay response on every transfer
// data sits in bits 15:0 of a word
// upper half always reads zero
//
// limits
// - an event wipes the armed key
//   each cycle, so only reset ends
//   a fault: a runaway program
//   cannot silence its own timer
// - counter reads are live; the
//   hold register keeps the upper
//   half seen at the last count read
// - hsize is ignored, one word each
// - unmapped or unaligned reads give
//   zero, writes there are dropped
// - fetch must come from the core
//   clock, it is not synchronised
//
`timescale 1ns/1ps
module fst_timer (
    input  wire logic        core_clk_in,        // system clock, 125 MHz
    input  wire logic        nrst_in,            // asynchronous reset, active low
    input  wire logic        fetch_in,           // one pulse per instruction fetch, same clock
    input  wire logic        cfg_timer_enable_in,// configuration-level enable
    input  wire logic        cfg_timer_disable_in,// configuration-level disable of software enable
    input  wire logic [15:0] match_word_low_in,  // configuration match word, low half
    input  wire logic [15:0] match_word_high_in, // configuration match word, high half
    input  wire logic [15:0] window_word_low_in, // configuration window word, low half
    input  wire logic [15:0] window_word_high_in,// configuration window word, high half
    input  wire logic        hsel_in,            // ahb slave select
    input  wire logic [31:0] haddr_in,           // ahb address
    input  wire logic [1:0]  htrans_in,          // ahb transfer type
    input  wire logic        hwrite_in,          // ahb write
    input  wire logic [2:0]  hsize_in,           // ahb size
    input  wire logic [31:0] hwdata_in,          // ahb write data
    input  wire logic        hready_in,          // ahb bus ready
    output logic      [31:0] hrdata_out,         // ahb read data
    output logic             hreadyout_out,      // ahb slave ready
    output logic             hresp_out,          // ahb response, always okay
    output logic             timer_event_out,    // level: timer event flag
    output logic             irq_out             // level interrupt
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0] counter;
    logic        sw_enable;
    logic [7:0]  first_key_field;
    logic        first_key_error;
    logic        second_key_error;
    logic        timer_event_flag;
    logic [15:0] held_upper_count;

    // interrupt bits follow the package; the read
    // mux packs them into 16 bits, no more fit
    localparam int IRQ_BITS_W = fst_pkg::IRQ_BITS;
    logic [IRQ_BITS_W-1:0] irq_status;
    logic [IRQ_BITS_W-1:0] irq_mask;

    if (IRQ_BITS_W < 1 || IRQ_BITS_W > 16) begin : g_irq_check
        $error("interrupt width out of range");
    end

    // address phase capture
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_index;
    logic        dp_bad;

    // register decode used by the first and second key write decodes
    function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
        hit = (idx == reg_idx);
    endfunction

    // ----------------------------------------------------------------
    // derived values
    // ----------------------------------------------------------------
    logic [31:0] match_cfg_value;
    logic [31:0] window_cfg_value;
    logic        timer_on;
    logic        matched;
    logic        window_open_flag;

    // the timer runs on the config
    // enable, or on the control bit
    // while the config disable is low
    //
    // match and window are plain
    // compares of the live counter
    assign match_cfg_value  = {match_word_high_in, match_word_low_in};
    assign window_cfg_value = {window_word_high_in, window_word_low_in};
    // software enable is ignored while the configuration disable is set
    assign timer_on = cfg_timer_enable_in | (sw_enable & ~cfg_timer_disable_in);
    assign matched  = timer_on & (counter >= match_cfg_value);
    // window opens once the count has reached the interval; a zero interval keeps it open
    assign window_open_flag = timer_on & (counter >= window_cfg_value);

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    logic addr_take;
    logic wr_now;
    logic rd_now;
    logic [15:0] wdata16;
    assign addr_take = hsel_in & hready_in & (htrans_in == fst_pkg::HTRANS_NONSEQ
                                            || htrans_in == fst_pkg::HTRANS_SEQ);
    assign wr_now  = dp_valid & dp_write & ~dp_bad;
    assign rd_now  = dp_valid & ~dp_write & ~dp_bad;
    assign wdata16 = hwdata_in[15:0];
    // zero wait states: every data phase completes in one cycle
    assign hreadyout_out = 1'b1;
    assign hresp_out     = fst_pkg::HRESP_OKAY;

    // the address phase is latched
    // every edge; only the valid bit
    // lets the data phase act, which
    // keeps index and direction free
    // of enables

    // capture the address phase
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_index <= 8'h00;
            dp_bad   <= 1'b0;
        end else begin
            dp_valid <= addr_take;
            dp_write <= hwrite_in;
            dp_index <= haddr_in[9:2];
            // unaligned or upper addresses decode as unmapped and read zero
            dp_bad   <= (haddr_in[1:0] != 2'b00) || (haddr_in[31:10] != 22'h0);
        end
    end

    // ----------------------------------------------------------------
    // keyed restart
    // ----------------------------------------------------------------
    // software arms the restart with
    // the first key in bits 15:8, then
    // confirms with the second key in
    // bits 7:0; each key is checked in
    // the data phase of its own write
    //
    // a wrong first key, a wrong second
    // key, a second key with nothing
    // armed, or one while the window is
    // shut is a bad sequence: its error
    // flag and the event rise together
    // and the armed key is lost
    //
    // a good sequence clears counter,
    // armed key and all three flags at
    // the edge ending the second write
    //

    // key decode for the data phase
    logic wr_first;
    logic wr_second;
    logic first_bad;
    logic second_bad;
    logic restart;
    assign wr_first   = wr_now && hit(dp_index, fst_pkg::IDX_FIRST_KEY);
    assign wr_second  = wr_now && hit(dp_index, fst_pkg::IDX_SECOND_KEY);
    assign first_bad  = wr_first && wdata16[15:8] != fst_pkg::FIRST_KEY_VALUE;
    // wrong value, no first key stored, or window closed are all bad sequences
    assign second_bad = wr_second && (wdata16[7:0] != fst_pkg::SECOND_KEY_VALUE
                        || first_key_field != fst_pkg::FIRST_KEY_VALUE
                        || !window_open_flag);
    assign restart    = wr_second && !second_bad;

    // the enable bit is plain read and
    // write; the config disable acts
    // on its use, not its storage

    // control register
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sw_enable <= 1'b0;
        end else if (wr_now && dp_index == fst_pkg::IDX_TIMER_CONTROL) begin
            sw_enable <= wdata16[fst_pkg::ENABLE_BIT];
        end
    end

    // the armed key is cleared every
    // cycle while the event is up
    //
    // first key field: a bad key is not stored, the event clears it
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            first_key_field <= 8'h00;
        end else if (restart || timer_event_flag || first_bad || second_bad) begin
            first_key_field <= 8'h00;
        end else if (wr_first) begin
            first_key_field <= wdata16[15:8];
        end
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            counter <= fst_pkg::CNT_RESET;
        end else if (restart) begin
            counter <= fst_pkg::CNT_RESET;
        end else if (timer_on && fetch_in && !matched && !timer_event_flag) begin
            counter <= counter + 32'h0000_0001;
        end
    end

    // flags clear only on a good
    // restart, which an event rules
    // out, so after a fault only
    // reset clears them
    //
    // status flags: hardware sets, a valid restart clears; set wins
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            first_key_error  <= 1'b0;
            second_key_error <= 1'b0;
            timer_event_flag <= 1'b0;
        end else begin
            if (first_bad) begin
                first_key_error <= 1'b1;
            end else if (restart) begin
                first_key_error <= 1'b0;
            end
            if (second_bad) begin
                second_key_error <= 1'b1;
            end else if (restart) begin
                second_key_error <= 1'b0;
            end
            if (matched || first_bad || second_bad) begin
                timer_event_flag <= 1'b1;
            end else if (restart) begin
                timer_event_flag <= 1'b0;
            end
        end
    end
    assign timer_event_out = timer_event_flag;

    // reading high then low lets
    // software spot a carry between
    // the reads against the hold copy
    //
    // hold register loads on either count read
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            held_upper_count <= fst_pkg::REG_RESET;
        end else if (rd_now && (dp_index == fst_pkg::IDX_COUNT_LOW
                                || dp_index == fst_pkg::IDX_COUNT_HIGH)) begin
            held_upper_count <= counter[31:16];
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    // each event also lands in a
    // sticky bit, so software tells
    // expiry from a bad key
    logic [IRQ_BITS_W-1:0] irq_set;
    always_comb begin
        irq_set = '0;
        irq_set[fst_pkg::IRQ_EXPIRE_BIT] = matched;
        irq_set[fst_pkg::IRQ_FIRST_KEY_ERROR_BIT]   = first_bad;
        irq_set[fst_pkg::IRQ_SECOND_KEY_ERROR_BIT]   = second_bad;
    end

    // write one to clear; a new event in the same cycle keeps its bit
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_status <= '0;
        end else if (wr_now && dp_index == fst_pkg::IDX_IRQ_STATUS) begin
            irq_status <= (irq_status & ~wdata16[IRQ_BITS_W-1:0]) | irq_set;
        end else begin
            irq_status <= irq_status | irq_set;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_mask <= '0;
        end else if (wr_now && dp_index == fst_pkg::IDX_IRQ_MASK) begin
            irq_mask <= wdata16[IRQ_BITS_W-1:0];
        end
    end
    assign irq_out = |(irq_status & irq_mask);

    // register map by word index,
    // the byte address is four times:
    //   5C control, bit 15 enable
    //   60 first key, bits 15:8
    //   64 second key, reads zero
    //   68 status: 7 bad first,
    //      6 bad second, 5 event,
    //      0 window open
    //   6C count low, live
    //   6E count high, live
    //   70 hold, upper half
    //   74/76 match words
    //   78/7A window words
    //   80 irq status, 81 irq mask:
    //      0 expiry, 1 bad first,
    //      2 bad second
    //   anything else reads zero

    // ----------------------------------------------------------------
    // read mux: data presented combinationally from registers in the data phase
    // ----------------------------------------------------------------
    logic [15:0] rd16;
    // only the low half carries data;
    // outside a read the mux gives 0
    always_comb begin
        rd16 = 16'h0000;
        if (!rd_now) begin
            rd16 = 16'h0000;
        end else if (dp_index == fst_pkg::IDX_TIMER_CONTROL) begin
            rd16[fst_pkg::ENABLE_BIT] = sw_enable;
        end else if (dp_index == fst_pkg::IDX_FIRST_KEY) begin
            rd16[15:8] = first_key_field;
        end else if (dp_index == fst_pkg::IDX_SECOND_KEY) begin
            rd16 = 16'h0000;                           // key reads back as zero
        end else if (dp_index == fst_pkg::IDX_TIMER_STATUS) begin
            rd16[fst_pkg::STAT_FIRST_KEY_ERROR_BIT]   = first_key_error;
            rd16[fst_pkg::STAT_SECOND_KEY_ERROR_BIT]   = second_key_error;
            rd16[fst_pkg::STAT_EVENT_BIT]  = timer_event_flag;
            rd16[fst_pkg::STAT_WINDOW_BIT] = window_open_flag;
        end else if (dp_index == fst_pkg::IDX_COUNT_LOW) begin
            rd16 = counter[15:0];
        end else if (dp_index == fst_pkg::IDX_COUNT_HIGH) begin
            rd16 = counter[31:16];
        end else if (dp_index == fst_pkg::IDX_COUNT_HOLD) begin
            rd16 = held_upper_count;
        end else if (dp_index == fst_pkg::IDX_MATCH_CFG_LOW) begin
            rd16 = match_word_low_in;
        end else if (dp_index == fst_pkg::IDX_MATCH_CFG_HIGH) begin
            rd16 = match_word_high_in;
        end else if (dp_index == fst_pkg::IDX_WINDOW_CFG_LOW) begin
            rd16 = window_word_low_in;
        end else if (dp_index == fst_pkg::IDX_WINDOW_CFG_HIGH) begin
            rd16 = window_word_high_in;
        end else if (dp_index == fst_pkg::IDX_IRQ_STATUS) begin
            rd16[IRQ_BITS_W-1:0] = irq_status;
        end else if (dp_index == fst_pkg::IDX_IRQ_MASK) begin
            rd16[IRQ_BITS_W-1:0] = irq_mask;
        end
    end
    assign hrdata_out = {16'h0000, rd16};

endmodule

/* test/fst_timer_asserts.sv */
// checker: bus answer and key-sequence properties seen at the timer's ports
`timescale 1ns/1ps
module fst_timer_chk (
    input wire logic        core_clk_in,        // clock
    input wire logic        nrst_in,            // reset, active low
    input wire logic        hsel_in,            // bus select
    input wire logic [31:0] haddr_in,           // bus address
    input wire logic [1:0]  htrans_in,          // transfer type
    input wire logic        hwrite_in,          // write strobe
    input wire logic [31:0] hwdata_in,          // write data
    input wire logic [15:0] match_word_low_in,  // match word, low half
    input wire logic [15:0] window_word_low_in, // window word, low half
    input wire logic [31:0] hrdata_out,         // read data
    input wire logic        hreadyout_out,      // slave ready
    input wire logic        hresp_out,          // response
    input wire logic        timer_event_out     // event level
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    logic       dp_wr;
    logic       dp_rd;
    logic [7:0] dp_idx;
    // data-phase tracking; a reset drops any phase in flight
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dp_wr  <= 1'b0;
            dp_rd  <= 1'b0;
            dp_idx <= 8'h00;
        end else begin
            dp_wr  <= hsel_in && htrans_in[1] && hwrite_in && hreadyout_out;
            dp_rd  <= hsel_in && htrans_in[1] && !hwrite_in && hreadyout_out;
            dp_idx <= haddr_in[9:2];
        end
    end
    bus_ready_a: assert property (hreadyout_out && !hresp_out) else $error("bus answer not ready or not okay");
    bad_first_a: assert property (dp_wr && dp_idx == fst_pkg::IDX_FIRST_KEY && hwdata_in[15:8] != 8'h40
        |=> timer_event_out) else $error("bad first key raised no event");
    bad_second_a: assert property (dp_wr && dp_idx == fst_pkg::IDX_SECOND_KEY && hwdata_in[7:0] != 8'h04
        |=> timer_event_out) else $error("bad second key raised no event");
    event_fall_a: assert property ($fell(timer_event_out) |-> $past(dp_wr)) else $error("event dropped alone");
    key2_zero_a: assert property (dp_rd && dp_idx == fst_pkg::IDX_SECOND_KEY |-> hrdata_out == 32'h0)
        else $error("second key read not zero");
    status_event_a: assert property (dp_rd && dp_idx == fst_pkg::IDX_TIMER_STATUS
        |-> hrdata_out[5] == timer_event_out && hrdata_out[31:8] == 24'h0) else $error("status event mismatch");
    match_mirror_a: assert property (dp_rd && dp_idx == fst_pkg::IDX_MATCH_CFG_LOW
        |-> hrdata_out == {16'h0000, match_word_low_in}) else $error("match mirror wrong");
    window_mirror_a: assert property (dp_rd && dp_idx == fst_pkg::IDX_WINDOW_CFG_LOW
        |-> hrdata_out == {16'h0000, window_word_low_in}) else $error("window mirror wrong");
endmodule
bind fst_timer fst_timer_chk fst_timer_chk_inst (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
    .match_word_low_in(match_word_low_in), .window_word_low_in(window_word_low_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .timer_event_out(timer_event_out));

/* test/fst_fetch_unit.sv */
// partner: instruction fetch unit issuing fetch pulses with random idle gaps
`timescale 1ns/1ps
module fst_fetch_unit (
    input  wire logic       core_clk_in, // clock
    input  wire logic       nrst_in,     // reset, active low
    input  wire logic [7:0] target_in,   // total fetches wanted
    output logic            fetch_out,   // one-cycle fetch pulse
    output logic      [7:0] issued_out   // fetches issued so far
);
    // idle gaps stand in for sleep and stalls, when no fetch reaches the timer
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fetch_out  <= 1'b0;
            issued_out <= 8'h00;
        end else if (issued_out != target_in && $urandom_range(1, 0) == 1) begin
            fetch_out  <= 1'b1;
            issued_out <= issued_out + 8'h01;
        end else begin
            fetch_out <= 1'b0;
        end
    end
endmodule

/* test/tb.sv */
// testbench: register bus, key sequences, expiry and interrupt of the fetch safety timer
`timescale 1ns/1ps
module tb;
    typedef struct {string nm; logic [31:0] v;} fst_note_type;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        cfg_en = 1'b0;
    logic        cfg_dis = 1'b0;
    logic [15:0] mlo = 16'h0010;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  target = 8'h00;
    logic        rd_dp = 1'b0;
    wire  [31:0] hrdata;
    wire         hready, hresp, tev, irq, fetch;
    wire  [7:0]  issued;
    int          err_total = 0;
    int          cmp_count = 0;
    fst_note_type q[$];
    fst_timer fst_timer_inst (.core_clk_in(clk), .nrst_in(nrst), .fetch_in(fetch), .cfg_timer_enable_in(cfg_en),
        .cfg_timer_disable_in(cfg_dis), .match_word_low_in(mlo), .match_word_high_in(16'h0000),
        .window_word_low_in(16'h0008), .window_word_high_in(16'h0000), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .timer_event_out(tev), .irq_out(irq));
    fst_fetch_unit fst_fetch_unit_inst (.core_clk_in(clk), .nrst_in(nrst), .target_in(target), .fetch_out(fetch),
        .issued_out(issued));
    always #4 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // single transfer; no latency is assumed, only the watchdog ends a wait
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= fst_pkg::HTRANS_NONSEQ;
        haddr  <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string nm);
        q.push_back('{nm, exp});
        bus(1'b0, idx, 32'h0);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        bus(1'b1, idx, {16'h0, d});
    endtask
    // levels are looked at mid-cycle, clear of the edge's own updates
    task automatic lvl(input logic ev, input logic iq);
        @(negedge clk);
        chk("event", {31'h0, ev}, {31'h0, tev});
        chk("irq", {31'h0, iq}, {31'h0, irq});
        @(posedge clk);
    endtask
    task automatic fetches(input int n);
        target <= target + n[7:0];
        @(posedge clk);
        while (issued !== target) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask
    task automatic do_reset();
        nrst   <= 1'b0;
        target <= 8'h00;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // each completed read takes the oldest note
    always @(posedge clk) begin
        if (rd_dp && q.size() > 0) begin
            chk(q[0].nm, q[0].v, hrdata);
            void'(q.pop_front());
        end
        rd_dp <= hsel && htrans == fst_pkg::HTRANS_NONSEQ && !hwrite && hready;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        int m;
        void'($urandom(32'h01FD));
        m = 16 + ($urandom % 16);
        mlo <= m[15:0];
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(fst_pkg::IDX_TIMER_CONTROL, 32'h0, "control");
        rd(fst_pkg::IDX_FIRST_KEY, 32'h0, "first key");
        rd(fst_pkg::IDX_COUNT_HIGH, 32'h0, "count high");
        rd(fst_pkg::IDX_COUNT_HOLD, 32'h0, "hold");
        rd(fst_pkg::IDX_MATCH_CFG_LOW, {16'h0, m[15:0]}, "match low");
        rd(fst_pkg::IDX_WINDOW_CFG_LOW, 32'h8, "window low");
        rd(8'h3F, 32'h0, "unmapped");
        wr(fst_pkg::IDX_COUNT_LOW, 16'hFFFF);
        wr(fst_pkg::IDX_TIMER_CONTROL, 16'h8000);
        rd(fst_pkg::IDX_TIMER_CONTROL, 32'h8000, "control on");
        fetches(5);
        rd(fst_pkg::IDX_TIMER_STATUS, 32'h0, "status closed");
        rd(fst_pkg::IDX_COUNT_LOW, 32'h5, "count low");
        fetches(5);
        rd(fst_pkg::IDX_TIMER_STATUS, 32'h1, "status open");
        wr(fst_pkg::IDX_FIRST_KEY, 16'h4000);
        rd(fst_pkg::IDX_FIRST_KEY, 32'h4000, "first key held");
        rd(fst_pkg::IDX_SECOND_KEY, 32'h0, "second key");
        wr(fst_pkg::IDX_SECOND_KEY, 16'h0004);
        rd(fst_pkg::IDX_COUNT_LOW, 32'h0, "count restart");
        rd(fst_pkg::IDX_FIRST_KEY, 32'h0, "first key cleared");
        lvl(1'b0, 1'b0);
        wr(fst_pkg::IDX_FIRST_KEY, 16'h4000);
        wr(fst_pkg::IDX_SECOND_KEY, 16'h0004);
        rd(fst_pkg::IDX_TIMER_STATUS, 32'h60, "status second_key_error");
        lvl(1'b1, 1'b0);
        // software enable held off by the configuration disable
        do_reset();
        cfg_dis <= 1'b1;
        wr(fst_pkg::IDX_TIMER_CONTROL, 16'h8000);
        fetches(3);
        rd(fst_pkg::IDX_COUNT_LOW, 32'h0, "count disabled");
        cfg_dis <= 1'b0;
        fetches(3);
        rd(fst_pkg::IDX_COUNT_LOW, 32'h3, "count enabled");
        wr(fst_pkg::IDX_FIRST_KEY, 16'h4100);
        rd(fst_pkg::IDX_TIMER_STATUS, 32'hA0, "status first_key_error");
        rd(fst_pkg::IDX_IRQ_STATUS, 32'h2, "irq status");
        lvl(1'b1, 1'b0);
        wr(fst_pkg::IDX_IRQ_MASK, 16'h0002);
        lvl(1'b1, 1'b1);
        wr(fst_pkg::IDX_IRQ_STATUS, 16'h0002);
        lvl(1'b1, 1'b0);
        wr(fst_pkg::IDX_SECOND_KEY, 16'h0005);
        rd(fst_pkg::IDX_TIMER_STATUS, 32'hE0, "status both");
        // expiry under the configuration enable: the counter stops at the match value
        do_reset();
        cfg_en <= 1'b1;
        fetches(m + 4);
        rd(fst_pkg::IDX_COUNT_LOW, {16'h0, m[15:0]}, "count at match");
        rd(fst_pkg::IDX_TIMER_STATUS, 32'h21, "status expired");
        rd(fst_pkg::IDX_IRQ_STATUS, 32'h1, "irq expired");
        lvl(1'b1, 1'b0);
        close_out();
    end
endmodule
